// ==== hw/wdr_pkg.sv ====
// package: register map, field positions and timing constants of the watchdog reset timer
package wdr_pkg;
   // ****************************************
   // register map (wishbone byte addresses, index times four)
   // ****************************************
   localparam logic [15:0] CTRL_STATUS_IDX = 16'hffbe;
   localparam logic [15:0] COUNTER_IDX     = 16'hffbf;
   localparam logic [15:0] IRQ_STATUS_IDX  = 16'hffc0;
   localparam logic [15:0] IRQ_MASK_IDX    = 16'hffc1;
   localparam logic [17:0] CTRL_STATUS_ADR = {CTRL_STATUS_IDX, 2'b00};
   localparam logic [17:0] COUNTER_ADR     = {COUNTER_IDX, 2'b00};
   localparam logic [17:0] IRQ_STATUS_ADR  = {IRQ_STATUS_IDX, 2'b00};
   localparam logic [17:0] IRQ_MASK_ADR    = {IRQ_MASK_IDX, 2'b00};

   // ****************************************
   // control/status fields
   // ****************************************
   localparam int COUNTER_ENABLE_GUARD_BIT = 7;
   localparam int COUNTER_WRITE_ENABLE_BIT = 6;
   localparam int CONTROL_ENABLE_GUARD_BIT = 5;
   localparam int CONTROL_WRITE_ENABLE_BIT = 4;
   localparam int RUN_GUARD_BIT            = 3;
   localparam int WATCHDOG_RUN_BIT         = 2;
   localparam int FLAG_GUARD_BIT           = 1;
   localparam int WATCHDOG_RESET_FLAG_BIT  = 0;
   localparam logic [7:0] CTRL_STATUS_RESET = 8'haa;
   localparam logic [7:0] COUNTER_RESET     = 8'h00;
   localparam logic [7:0] COUNTER_MAX       = 8'hff;

   // irq status bits: 0 = counter tick, 1 = overflow
   localparam int IRQ_TICK_BIT     = 0;
   localparam int IRQ_OVERFLOW_BIT = 1;

   // ****************************************
   // timing
   // ****************************************
   localparam int PRESCALE_DIV      = 8192;
   localparam int CHIP_RESET_CYCLES = 512;
endpackage

// ==== hw/wdr_top.sv ====
// module: watchdog reset timer with wishbone register slave
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module wdr_top #(
   parameter int PRESCALE    = wdr_pkg::PRESCALE_DIV,
   parameter int RESET_HOLD  = wdr_pkg::CHIP_RESET_CYCLES
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [17:0] wb_adr_in,
   input  wire logic [31:0] wb_dat_in,
   input  wire logic [3:0]  wb_sel_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   output logic             wb_err_out,
   output logic             chip_reset_out,
   output logic             irq_out
);
   // ****************************************
   // state
   // ****************************************
   logic        counter_write_enable;
   logic        control_write_enable;
   logic        watchdog_run;
   logic        watchdog_reset_flag;
   logic [7:0]  watchdog_counter;
   logic [12:0] prescale_cnt;
   logic        tick;
   logic [9:0]  hold_cnt;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic        core_rst;
   logic        overflow;

   // rst_in is the external pin reset; the chip reset we drive out also resets
   // our own control state, but never the flag
   assign core_rst = rst_in || chip_reset_out;

   // ****************************************
   // bus decode
   // ****************************************
   logic req;
   logic wr_lane0;
   logic hit_cs;
   logic hit_cnt;
   logic hit_ist;
   logic hit_imk;
   logic [7:0] wd;

   assign req      = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
   assign hit_cs   = wb_adr_in == wdr_pkg::CTRL_STATUS_ADR;
   assign hit_cnt  = wb_adr_in == wdr_pkg::COUNTER_ADR;
   assign hit_ist  = wb_adr_in == wdr_pkg::IRQ_STATUS_ADR;
   assign hit_imk  = wb_adr_in == wdr_pkg::IRQ_MASK_ADR;
   assign wr_lane0 = req && wb_we_in && wb_sel_in[0];
   assign wd       = wb_dat_in[7:0];

   // ****************************************
   // prescaler: one tick pulse every PRESCALE clocks
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (core_rst || !watchdog_run) begin
         prescale_cnt <= '0;
         tick         <= 1'b0;
      end else if (prescale_cnt == 13'(PRESCALE - 1)) begin
         prescale_cnt <= '0;
         tick         <= 1'b1;
      end else begin
         prescale_cnt <= prescale_cnt + 13'h0001;
         tick         <= 1'b0;
      end
   end

   assign overflow = tick && watchdog_run && watchdog_counter == wdr_pkg::COUNTER_MAX
                     && !(wr_lane0 && hit_cnt && counter_write_enable);

   // ****************************************
   // counter
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (core_rst) begin
         watchdog_counter <= wdr_pkg::COUNTER_RESET;
      end else if (wr_lane0 && hit_cnt && counter_write_enable) begin
         // a load wins over a coincident tick; counting goes on from it
         watchdog_counter <= wd;
      end else if (tick && watchdog_run) begin
         watchdog_counter <= watchdog_counter + 8'h01;
      end
   end

   // ****************************************
   // protected control bits
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (core_rst) begin
         counter_write_enable <= 1'b0;
         control_write_enable <= 1'b0;
         watchdog_run         <= 1'b0;
      end else if (wr_lane0 && hit_cs) begin
         if (!wd[wdr_pkg::COUNTER_ENABLE_GUARD_BIT]) begin
            counter_write_enable <= wd[wdr_pkg::COUNTER_WRITE_ENABLE_BIT];
         end
         if (!wd[wdr_pkg::CONTROL_ENABLE_GUARD_BIT]) begin
            control_write_enable <= wd[wdr_pkg::CONTROL_WRITE_ENABLE_BIT];
         end
         // uses the enable as it stood before this write, so starting needs two writes
         if (control_write_enable && !wd[wdr_pkg::RUN_GUARD_BIT]) begin
            watchdog_run <= wd[wdr_pkg::WATCHDOG_RUN_BIT];
         end
      end
   end

   // flag is cleared by the pin reset or a control write with control enable set, not by the chip reset it caused
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         watchdog_reset_flag <= 1'b0;
      end else if (overflow) begin
         watchdog_reset_flag <= 1'b1;
      end else if (wr_lane0 && hit_cs && control_write_enable
                   && !wd[wdr_pkg::FLAG_GUARD_BIT] && !wd[wdr_pkg::WATCHDOG_RESET_FLAG_BIT]) begin
         watchdog_reset_flag <= 1'b0;
      end
   end

   // ****************************************
   // chip reset pulse; the oscillator clock is taken to be mclk_in
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         hold_cnt       <= '0;
         chip_reset_out <= 1'b0;
      end else if (overflow) begin
         hold_cnt       <= 10'(RESET_HOLD - 1);
         chip_reset_out <= 1'b1;
      end else if (hold_cnt != 10'h000) begin
         hold_cnt <= hold_cnt - 10'h001;
      end else begin
         chip_reset_out <= 1'b0;
      end
   end

   // ****************************************
   // interrupts: sticky, cleared by reading status; set wins over clear
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_status <= '0;
      end else begin
         irq_status <= (req && !wb_we_in && hit_ist) ? 2'b00 : irq_status;
         if (tick && watchdog_run) begin
            irq_status[wdr_pkg::IRQ_TICK_BIT] <= 1'b1;
         end
         if (overflow) begin
            irq_status[wdr_pkg::IRQ_OVERFLOW_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_mask <= '0;
      end else if (wr_lane0 && hit_imk) begin
         irq_mask <= wd[1:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_status & irq_mask);
      end
   end

   // ****************************************
   // bus answer: one wait-free ack (err for an unmapped address) the cycle after the request
   // ****************************************
   logic [7:0] cs_read;
   logic       hit_any;

   assign hit_any = hit_cs || hit_cnt || hit_ist || hit_imk;
   // guard bits always read as one
   assign cs_read = {1'b1, counter_write_enable, 1'b1, control_write_enable,
                     1'b1, watchdog_run, 1'b1, watchdog_reset_flag};

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_err_out <= 1'b0;
         wb_dat_out <= '0;
      end else begin
         wb_ack_out <= req && hit_any;
         wb_err_out <= req && !hit_any;
         wb_dat_out <= '0;
         if (req && !wb_we_in) begin
            if (hit_cs) begin
               wb_dat_out <= {24'h000000, cs_read};
            end else if (hit_cnt) begin
               wb_dat_out <= {24'h000000, watchdog_counter};
            end else if (hit_ist) begin
               wb_dat_out <= {30'h00000000, irq_status};
            end else if (hit_imk) begin
               wb_dat_out <= {30'h00000000, irq_mask};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// testbench: register-level scenarios for the watchdog reset timer
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ****************************************
   // stimulus and checks
   // ****************************************
   localparam logic [17:0] CS = wdr_pkg::CTRL_STATUS_ADR;
   localparam logic [17:0] CNT = wdr_pkg::COUNTER_ADR;
   logic        mclk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        wb_cyc_in = 1'b0;
   logic        wb_stb_in = 1'b0;
   logic        wb_we_in = 1'b0;
   logic [17:0] wb_adr_in = 18'h00000;
   logic [31:0] wb_dat_in = 32'h00000000;
   logic [3:0]  wb_sel_in = 4'h1;
   logic [31:0] wb_dat_out;
   logic        wb_ack_out, wb_err_out, chip_reset_out, irq_out, er;
   logic [7:0]  rd;
   int          errors = 0, total_checks = 0, n;
   always #5 mclk_in = ~mclk_in;
   wdr_top #(.PRESCALE(8), .RESET_HOLD(4)) uut (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in,
      .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_sel_in, .wb_dat_out, .wb_ack_out, .wb_err_out,
      .chip_reset_out, .irq_out);
   task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_sel_in <= 4'h1;
      wb_adr_in <= a;
      wb_dat_in <= {24'h000000, d};
      do @(posedge mclk_in); while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1);
      rd = wb_dat_out[7:0];
      er = wb_err_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [17:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rd, e);
   endtask
   task automatic complete_run;
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      rchk(CS, 8'haa);
      rchk(CNT, 8'h00);
      xfer(1'b1, CNT, 8'h55);
      rchk(CNT, 8'h00);
      xfer(1'b1, CS, 8'h04);
      rchk(CS, 8'haa);
      xfer(1'b1, CS, 8'hff);
      rchk(CS, 8'haa);
      xfer(1'b1, CS, 8'h50);
      rchk(CS, 8'hfa);
      xfer(1'b1, CNT, 8'hfc);
      rchk(CNT, 8'hfc);
      xfer(1'b1, CS, 8'h54);
      n = 0;
      while (chip_reset_out !== 1'b1 && n < 100) begin
         @(posedge mclk_in);
         n++;
      end
      // four ticks of eight clocks from the loaded value, plus start and flop lag
      chk((n == 33) ? 8'h01 : 8'h00, 8'h01);
      repeat (6) @(posedge mclk_in);
      rchk(CS, 8'hab);
      rchk(CNT, 8'h00);
      chk({7'h00, irq_out}, 8'h00);
      xfer(1'b1, wdr_pkg::IRQ_MASK_ADR, 8'h02);
      repeat (2) @(posedge mclk_in);
      chk({7'h00, irq_out}, 8'h01);
      rchk(wdr_pkg::IRQ_STATUS_ADR, 8'h03);
      repeat (2) @(posedge mclk_in);
      chk({7'h00, irq_out}, 8'h00);
      // the first write only opens control enable; the second may clear the flag
      xfer(1'b1, CS, 8'h10);
      xfer(1'b1, CS, 8'h10);
      rchk(CS, 8'hba);
      xfer(1'b1, CS, 8'h14);
      rchk(CS, 8'hbe);
      repeat (40) @(posedge mclk_in);
      xfer(1'b1, CS, 8'h10);
      rchk(CS, 8'hba);
      rchk(CNT, 8'h05);
      repeat (20) @(posedge mclk_in);
      rchk(CNT, 8'h05);
      xfer(1'b0, 18'h00000, 8'h00);
      chk({7'h00, er}, 8'h01);
      complete_run;
   end
   initial begin
      #100000;
      errors++;
      complete_run;
   end
endmodule
`default_nettype wire

// ==== sim/wdr_top_properties.sv ====
// checker: port-level properties of the watchdog reset timer
`timescale 1ns/10ps
`default_nettype none
module wdr_props #(
   parameter int PRESCALE   = 8,
   parameter int RESET_HOLD = 4
) (
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [17:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0]  wb_sel_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic        wb_err_out,
   input wire logic        chip_reset_out,
   input wire logic        irq_out
);
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // counts how long the chip reset has stood; a counter avoids a long repetition
   logic [9:0] hold_cnt;
   always_ff @(posedge mclk_in) begin
      hold_cnt <= chip_reset_out ? hold_cnt + 10'h001 : 10'h000;
   end
   a_reset_hold_len: assert property ($fell(chip_reset_out) |-> hold_cnt == RESET_HOLD)
      else $error("chip reset held for the wrong number of cycles");
   a_reset_hold_max: assert property (hold_cnt <= RESET_HOLD)
      else $error("chip reset held too long");
   // the default disable would switch this off exactly when it applies, so it opts out
   a_pin_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !chip_reset_out && !irq_out)
      else $error("outputs active after pin reset");
   a_ack_answers_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out
      |=> wb_ack_out || wb_err_out) else $error("request not answered next cycle");
   a_ack_one_cycle: assert property (wb_ack_out || wb_err_out |=> !wb_ack_out && !wb_err_out)
      else $error("answer stood longer than one cycle");
   a_ack_has_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   a_dat_zero_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h00000000)
      else $error("read data not zero outside ack");
   a_guard_bits_one: assert property (wb_ack_out && !$past(wb_we_in)
      && $past(wb_adr_in) == wdr_pkg::CTRL_STATUS_ADR |-> (wb_dat_out[7:0] & 8'haa) == 8'haa)
      else $error("guard bit read as zero");
endmodule
bind wdr_top wdr_props #(.PRESCALE(PRESCALE), .RESET_HOLD(RESET_HOLD)) u_props (.mclk_in,
   .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_sel_in,
   .wb_dat_out, .wb_ack_out, .wb_err_out, .chip_reset_out, .irq_out);
`default_nettype wire
